/* File: verif/fpt_fan_model.sv */
// fan with half period input and tachometer output, plus the board slow oscillator
// assumes outputs are sampled on the same clock as the block
`timescale 1ns/1ps
`default_nettype none
module fpt_fan_model (
    input wire logic clk,
    input wire logic [15:0] half_period, // tach half period, 0 = stalled
    output logic tach,
    output logic slow_clk
);
    logic [15:0] tcnt = 16'h0000; // tach half period count
    logic [1:0] scnt = 2'b00; // oscillator sped up to keep runs short
    initial tach = 1'b0;
    initial slow_clk = 1'b0;
    always @(posedge clk) begin
        scnt <= scnt + 2'b01;
        if (scnt == 2'b11) begin
            slow_clk <= ~slow_clk;
        end
        if (half_period == 16'h0000) begin
            tcnt <= 16'h0000;
        end else if (tcnt + 16'h0001 >= half_period) begin
            tcnt <= 16'h0000;
            tach <= ~tach;
        end else begin
            tcnt <= tcnt + 16'h0001;
        end
    end
endmodule : fpt_fan_model
`default_nettype wire

/* File: verif/fpt_top_sva.sv */
// checker for the fan modulator top, watching its ports only
// assumes hready is fed back from hreadyout by the single master
`timescale 1ns/1ps
`default_nettype none
module fpt_top_sva
    import fpt_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic HSEL,
    input wire logic [ADDR_W-1:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic FAN_OUT,
    input wire logic FAN_OUT_EN,
    input wire logic WAKE_EVENT_PIN_O,
    input wire logic WAKE_EVENT_PIN_OE,
    input wire logic SMI_EVENT,
    input wire logic IRQ
);
    logic wr_ph; // write data phase under way
    logic hit; // that write aims at the fan output setting
    logic [7:0] fos; // shadow of the fan output setting
    logic [12:0] low_cnt; // cycles with force and duty both zero
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // shadow follows the commit edge, where hreadyout is low
    always_ff @(posedge CLK) begin
        if (RESET) begin
            wr_ph <= 1'b0;
            hit <= 1'b0;
            fos <= 8'h00;
        end else begin
            if (HREADYOUT) begin
                wr_ph <= HSEL && HTRANS[1] && HWRITE && HREADY;
                hit <= HADDR == ADDR_W'({FAN_OUTPUT_IDX, 2'b00});
            end
            if (wr_ph && !HREADYOUT && hit) begin
                fos <= HWDATA[7:0];
            end
        end
    end
    // saturates well past two of the longest periods in use
    always_ff @(posedge CLK) begin
        if (RESET || fos[6:0] != 7'h00) begin
            low_cnt <= 13'h0000;
        end else if (low_cnt != 13'h1FFF) begin
            low_cnt <= low_cnt + 13'h0001;
        end
    end
    chk_reset_out_low: assert property ($fell(RESET) |-> !FAN_OUT)
        else $error("out high at reset");
    chk_pin_is_output: assert property (FAN_OUT_EN)
        else $error("pin off");
    chk_wake_open_drain: assert property (!WAKE_EVENT_PIN_O)
        else $error("wake high");
    chk_write_one_wait: assert property (HSEL && HTRANS[1] && HWRITE
        && HREADY |=> !HREADYOUT ##1 HREADYOUT) else $error("write wait");
    chk_read_no_wait: assert property (HSEL && HTRANS[1] && !HWRITE
        && HREADY |=> HREADYOUT) else $error("read stalled");
    chk_force_high: assert property (fos[0] |=> FAN_OUT)
        else $error("force low");
    chk_zero_duty_low: assert property (
        low_cnt == 13'h1FFF |-> !FAN_OUT) else $error("duty 0 high");
    chk_smi_drop_write: assert property (
        $fell(SMI_EVENT) |-> !$past(HREADYOUT)) else $error("smi drop");
    chk_wake_drop_write: assert property (
        $fell(WAKE_EVENT_PIN_OE) |-> !$past(HREADYOUT))
        else $error("wake drop");
    cover property (FAN_OUT ##1 !FAN_OUT);
    cover property ($rose(SMI_EVENT));
    cover property ($rose(IRQ));
endmodule : fpt_top_sva
bind fpt_top fpt_top_sva #(.ADDR_W(ADDR_W)) chk (.CLK(CLK), .RESET(RESET),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
    .FAN_OUT(FAN_OUT), .FAN_OUT_EN(FAN_OUT_EN),
    .WAKE_EVENT_PIN_O(WAKE_EVENT_PIN_O),
    .WAKE_EVENT_PIN_OE(WAKE_EVENT_PIN_OE), .SMI_EVENT(SMI_EVENT), .IRQ(IRQ));
`default_nettype wire

/* File: verif/test_fan_pwm_and_tachometer.sv */
// self-checking bench for the fan modulator and tachometer block
// assumes the small slow-period parameters set below
`timescale 1ns/1ps
`default_nettype none
module test_fan_pwm_and_tachometer;
    import fpt_pkg::*;
    logic clk, rst, hsel, hwrite, hrdy, hresp, tach, slow, wpin;
    logic fan, fan_en, wo, woe, smi, irq;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic [7:0] d;
    logic [15:0] half;
    int failures = 0;
    int compares = 0;
    assign wpin = !(woe && !wo); // pulled up unless the block sinks it
    fpt_top #(.DIV_SLOW0(8), .DIV_SLOW1(6), .DIV_SLOW0_X2(4),
        .DIV_SLOW1_X2(3)) uut (.CLK(clk), .RESET(rst), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
        .HRESP(hresp), .FAN_PULSE_INPUT(tach), .SLOW_CLOCK_PIN(slow),
        .WAKE_EVENT_PIN_I(wpin), .FAN_OUT(fan), .FAN_OUT_EN(fan_en),
        .WAKE_EVENT_PIN_O(wo), .WAKE_EVENT_PIN_OE(woe), .SMI_EVENT(smi),
        .IRQ(irq));
    fpt_fan_model fan_m (.clk(clk), .half_period(half),
        .tach(tach), .slow_clk(slow));
    task automatic chk(input logic [31:0] got, lo, hi, input string what);
        compares++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            failures++;
            $display("MISMATCH %0t %s got %0h", $time, what, got);
        end
    endtask : chk
    // address phase, held until hready is seen high
    task automatic put(input logic [7:0] idx, input logic w);
        hsel <= 1'b1;
        haddr <= {2'b00, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'b00;
    endtask : put
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        put(idx, 1'b1);
        hwdata <= {24'h00_0000, v};
        do @(posedge clk); while (hrdy !== 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] idx, output logic [7:0] v);
        put(idx, 1'b0);
        do @(posedge clk); while (hrdy !== 1'b1);
        v = hrdata[7:0];
        chk(hresp, 1'b0, 1'b0, "resp");
    endtask : rd
    task automatic t_reset;
        rd(FAN_OUTPUT_IDX, d);
        chk(d, 8'h00, 8'h00, "fos rst");
        rd(FAN_CONTROL_IDX, d);
        chk(d, 8'h10, 8'h10, "fcs rst");
        chk(fan, 1'b0, 1'b0, "pin low");
        rd(8'h57, d);
        chk(d, 8'h00, 8'h00, "unmapped");
        wr(FAN_CONTROL_IDX, 8'hFF);
        rd(FAN_CONTROL_IDX, d);
        chk(d, 8'h35, 8'h35, "layout");
    endtask : t_reset
    task automatic t_tach;
        wr(SLOW_CFG_IDX, 8'h01);
        wr(FAN_CONTROL_IDX, 8'h00);
        wr(PRELOAD_IDX, 8'hF0);
        rd(TACH_COUNT_IDX, d);
        chk(d, 8'hF0, 8'hF2, "preload");
        repeat (200) @(posedge clk);
        rd(TACH_COUNT_IDX, d);
        chk(d, 8'hFF, 8'hFF, "saturate");
        half <= 16'h0190;
        @(posedge tach);
        half <= 16'h0000;
        repeat (2) @(posedge clk);
        rd(TACH_COUNT_IDX, d);
        chk(d, 8'hF0, 8'hF2, "pulse");
        // one tick every 8 clocks, widened by the divisor code
        for (int k = 0; k < 4; k++) begin
            wr(FAN_CONTROL_IDX, {2'b00, 2'(k), 4'h0});
            wr(PRELOAD_IDX, 8'h00);
            repeat (800) @(posedge clk);
            rd(TACH_COUNT_IDX, d);
            chk(d, (100 >> k) - 2, (100 >> k) + 2, "divided");
        end
    endtask : t_tach
    task automatic t_wake;
        wr(FAN_CONTROL_IDX, 8'h00);
        wr(WAKE_STS_IDX, 8'h01);
        rd(IRQ_STS_IDX, d);
        wr(PRELOAD_IDX, 8'hB0);
        repeat (200) @(posedge clk);
        chk({irq, smi, woe}, 3'h0, 3'h0, "gated");
        wr(WAKE_EN_IDX, 8'h03);
        wr(IRQ_MASK_IDX, 8'h01);
        chk({irq, smi, woe}, 3'h7, 3'h7, "raised");
        rd(WAKE_STS_IDX, d);
        chk(d, 8'h01, 8'h01, "wake sts");
        wr(WAKE_STS_IDX, 8'h00);
        chk({smi, woe}, 2'h3, 2'h3, "w0 keeps");
        wr(WAKE_STS_IDX, 8'h01);
        chk({smi, woe}, 2'h0, 2'h0, "w1 clears");
        rd(IRQ_STS_IDX, d);
        chk({d, irq}, 9'h002, 9'h002, "irq clear");
    endtask : t_wake
    task automatic t_pwm;
        int slot[8] = '{40, 27, 8, 6, 20, 13, 4, 3};
        realtime t0, t1, t2;
        logic [5:0] duty;
        for (int m = 0; m < 8; m++) begin
            duty = 6'(63 - m * 8);
            wr(FAN_OUTPUT_IDX, {m[0], duty, 1'b0});
            wr(FAN_CONTROL_IDX, {4'h1, 1'b0, m[2], 1'b0, m[1]});
            @(posedge fan) t0 = $realtime / 25.0;
            @(negedge fan) t1 = $realtime / 25.0;
            @(posedge fan) t2 = $realtime / 25.0;
            chk(int'(t1 - t0), duty * slot[m], duty * slot[m], "high");
            chk(int'(t2 - t0), 64 * slot[m], 64 * slot[m], "period");
        end
        wr(FAN_OUTPUT_IDX, 8'h01);
        repeat (3) @(posedge clk);
        chk(fan, 1'b1, 1'b1, "forced");
        wr(FAN_OUTPUT_IDX, 8'h00);
        wr(FAN_CONTROL_IDX, 8'h10);
        repeat (8400) @(posedge clk);
        chk(fan, 1'b0, 1'b0, "zero duty");
    endtask : t_pwm
    task automatic print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        print_verdict();
    end
    initial begin
        {rst, hsel, hwrite, htrans, haddr, hwdata, half} = '0;
        rst = 1'b1;
        hsize = 3'h2;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_tach();
        t_wake();
        t_pwm();
        print_verdict();
    end
endmodule : test_fan_pwm_and_tachometer
`default_nettype wire

/* File: verilog/fpt_if.sv */
// carrier between the register/modulator top and the tachometer counter
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface fpt_if;
    import fpt_pkg::*;
    logic [7:0] preload;    // value loaded at each restart
    fpt_div_t divisor;      // count clock divisor
    logic ext_sel;          // 1 selects the external slow clock pin
    logic preload_wr;       // one-cycle pulse on a preload write
    logic slow_pin;         // external slow clock pin level
    logic pulse_in;         // tachometer pulse level
    logic [7:0] count;      // live tachometer count
    logic thresh_evt;       // one-cycle pulse when count reaches 192
    logic pulse_evt;        // one-cycle pulse on each tachometer rise
    modport ctl(output preload, divisor, ext_sel, preload_wr, slow_pin,
                pulse_in, input count, thresh_evt, pulse_evt);
    modport tach(input preload, divisor, ext_sel, preload_wr, slow_pin,
                 pulse_in, output count, thresh_evt, pulse_evt);
endinterface : fpt_if
`default_nettype wire

/* File: verilog/fpt_pkg.sv */
// constants shared by the fan modulator, the tachometer counter and the bus
// assumes a 40 MHz system clock and a 32-bit ahb-lite register bus
package fpt_pkg;
    // system clock rate in hz
    localparam int CLK_HZ = 40_000_000;
    // slots per modulator period
    localparam int PWM_SLOTS = 64;
    // output frequencies in hz, multiplier off
    localparam int F_FAST0_HZ = 15_625;
    localparam int F_FAST1_HZ = 23_438;
    localparam int F_SLOW0_HZ = 40;
    localparam int F_SLOW1_HZ = 60;
    // system clocks per slot, rounded to nearest with multiplier off, halved and truncated with it on
    localparam int DIV_FAST0 = (CLK_HZ + F_FAST0_HZ * PWM_SLOTS / 2) /
                               (F_FAST0_HZ * PWM_SLOTS);
    localparam int DIV_FAST1 = (CLK_HZ + F_FAST1_HZ * PWM_SLOTS / 2) /
                               (F_FAST1_HZ * PWM_SLOTS);
    localparam int DIV_FAST0_X2 = DIV_FAST0 / 2;
    localparam int DIV_FAST1_X2 = DIV_FAST1 / 2;
    localparam int DIV_SLOW0_DEF = (CLK_HZ + F_SLOW0_HZ * PWM_SLOTS / 2) /
                                   (F_SLOW0_HZ * PWM_SLOTS);
    localparam int DIV_SLOW1_DEF = (CLK_HZ + F_SLOW1_HZ * PWM_SLOTS / 2) /
                                   (F_SLOW1_HZ * PWM_SLOTS);
    localparam int DIV_SLOW0_X2_DEF = DIV_SLOW0_DEF / 2;
    localparam int DIV_SLOW1_X2_DEF = DIV_SLOW1_DEF / 2;
    localparam int DIV_W = 16;
    // internal slow clock, about 32.768 khz made from the system clock
    localparam int SLOW_HZ = 32_768;
    localparam int INT_SLOW_DIV = (CLK_HZ + SLOW_HZ / 2) / SLOW_HZ;
    localparam int INT_W = 11;
    // register indices; byte address is four times the index
    localparam logic [7:0] FAN_OUTPUT_IDX = 8'h56;
    localparam logic [7:0] FAN_CONTROL_IDX = 8'h58;
    localparam logic [7:0] PRELOAD_IDX = 8'h59;
    localparam logic [7:0] TACH_COUNT_IDX = 8'h5A;
    localparam logic [7:0] WAKE_STS_IDX = 8'h5B;
    localparam logic [7:0] WAKE_EN_IDX = 8'h5C;
    localparam logic [7:0] SLOW_CFG_IDX = 8'h5D;
    localparam logic [7:0] IRQ_STS_IDX = 8'h5E;
    localparam logic [7:0] IRQ_MASK_IDX = 8'h5F;
    // field positions
    localparam int FOS_CLKCTL_BIT = 0;
    localparam int FOS_DUTY_LSB = 1;
    localparam int FOS_DUTY_MSB = 6;
    localparam int FOS_CLKSEL_BIT = 7;
    localparam int FCS_SRC_BIT = 0;
    localparam int FCS_MUL_BIT = 2;
    localparam int FCS_DIV_LSB = 4;
    localparam int FCS_DIV_MSB = 5;
    // reset values and masks
    localparam logic [7:0] FOS_RESET = 8'h00;
    localparam logic [7:0] FCS_RESET = 8'h10;
    localparam logic [7:0] FCS_MASK = 8'h35;
    localparam logic [7:0] PRELOAD_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [5:0] SLOT_LAST = 6'h3F;
    // ahb-lite codes
    localparam logic HRESP_OKAY = 1'b0;
    // tachometer count clock divisor codes
    typedef enum logic [1:0] {
        FPT_DIV1 = 2'b00,
        FPT_DIV2 = 2'b01,
        FPT_DIV4 = 2'b10,
        FPT_DIV8 = 2'b11
    } fpt_div_t;
endpackage : fpt_pkg

/* File: verilog/fpt_tach.sv */
// tachometer counter: gated, divided slow clock into a saturating counter
// assumes slow clock pin and tachometer pulse are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module fpt_tach
    import fpt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    fpt_if.tach tif
);
    logic slow_prev;        // last slow pin level for edge detect
    logic pulse_prev;       // last tachometer level for edge detect
    logic [INT_W-1:0] int_cnt; // internal slow clock divider
    logic [2:0] pre;        // count clock prescaler
    logic hi_prev;          // two top count bits were both set
    logic base_tick;
    logic div_tick;
    logic restart;

    // prescaler mask for a divisor code
    function automatic logic [2:0] div_mask(input fpt_div_t d);
        unique case (d)
            FPT_DIV1: div_mask = 3'h0;
            FPT_DIV2: div_mask = 3'h1;
            FPT_DIV4: div_mask = 3'h3;
            FPT_DIV8: div_mask = 3'h7;
        endcase
    endfunction : div_mask

    // edge history of both pin levels
    always_ff @(posedge clk) begin
        if (rst) begin
            slow_prev <= 1'b0;
            pulse_prev <= 1'b0;
        end else begin
            slow_prev <= tif.slow_pin;
            pulse_prev <= tif.pulse_in;
        end
    end

    // internal stand-in for the slow clock when no crystal is fitted
    always_ff @(posedge clk) begin
        if (rst || int_cnt == INT_W'(INT_SLOW_DIV - 1)) begin
            int_cnt <= '0;
        end else begin
            int_cnt <= int_cnt + INT_W'(1);
        end
    end

    // source choice between pin and internal clock
    assign base_tick = tif.ext_sel ? (tif.slow_pin & ~slow_prev)
                                   : (int_cnt == INT_W'(INT_SLOW_DIV - 1));
    // divide by 1, 2, 4 or 8
    assign div_tick = base_tick && ((pre & div_mask(tif.divisor)) ==
                                    div_mask(tif.divisor));
    // restart on each tachometer rise and on a preload write
    assign restart = (tif.pulse_in & ~pulse_prev) | tif.preload_wr;
    assign tif.pulse_evt = tif.pulse_in & ~pulse_prev;

    // prescaler restarts with the counter so each period starts aligned
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            pre <= 3'h0;
        end else if (base_tick) begin
            pre <= pre + 3'h1;
        end
    end

    // 8-bit count of divided ticks over one pulse period
    always_ff @(posedge clk) begin
        if (rst) begin
            tif.count <= PRELOAD_RESET;
        end else if (restart) begin
            tif.count <= tif.preload;
        end else if (div_tick && tif.count != COUNT_MAX) begin
            tif.count <= tif.count + 8'h01; // holds at all ones
        end
    end

    // event on the rise of both top bits, i.e. count 192
    always_ff @(posedge clk) begin
        if (rst) begin
            hi_prev <= 1'b0;
        end else begin
            hi_prev <= &tif.count[7:6];
        end
    end
    assign tif.thresh_evt = (&tif.count[7:6]) & ~hi_prev;
endmodule : fpt_tach
`default_nettype wire

/* File: verilog/fpt_top.sv */
// fan modulator and tachometer monitor with an ahb-lite register slave
// assumes one ahb-lite master, word accesses only, pins synchronous to CLK
`timescale 1ns/1ps
`default_nettype none
module fpt_top
    import fpt_pkg::*;
#(
    parameter int DIV_SLOW0 = DIV_SLOW0_DEF,
    parameter int DIV_SLOW1 = DIV_SLOW1_DEF,
    parameter int DIV_SLOW0_X2 = DIV_SLOW0_X2_DEF,
    parameter int DIV_SLOW1_X2 = DIV_SLOW1_X2_DEF,
    parameter int ADDR_W = 12
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic HSEL,
    input wire logic [ADDR_W-1:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic FAN_PULSE_INPUT,
    input wire logic SLOW_CLOCK_PIN,
    input wire logic WAKE_EVENT_PIN_I,
    output logic FAN_OUT,
    output logic FAN_OUT_EN,
    output logic WAKE_EVENT_PIN_O,
    output logic WAKE_EVENT_PIN_OE,
    output logic SMI_EVENT,
    output logic IRQ
);
    fpt_if tif();           // link to the tachometer counter

    // software-visible state
    logic [7:0] fan_output_setting;  // clock control, duty, clock select
    logic [7:0] fan_control_setting; // source, multiplier, divisor
    logic [7:0] preload;             // tachometer preload value
    logic wake_status;               // sticky threshold wake status
    logic [1:0] wake_en;             // bit0 wake enable, bit1 smi enable
    logic ext_slow_clock_present;    // slow clock source choice
    logic [1:0] irq_status;          // bit0 threshold, bit1 new pulse
    logic [1:0] irq_mask;            // same layout as irq_status

    // bus slave state
    logic acc;              // address phase accepted this edge
    logic wr_ph;            // a write data phase is open
    logic wr_done;          // the open write has been committed
    logic wr_commit;        // commit cycle of a write
    logic [ADDR_W-1:0] wr_addr; // address held for the data phase
    logic [31:0] next_rdata;    // read word for the accepted address
    logic irq_rd_clr;       // read of irq status clears it

    // modulator state
    logic [DIV_W-1:0] div_cnt;  // system clocks within a slot
    logic [DIV_W-1:0] act_div;  // slot length minus one in force
    logic [5:0] slot;           // slot number within the period
    logic [5:0] act_duty;       // duty code in force
    logic slot_tick;
    logic boundary;

    // address match for a register index; word aligned only
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] idx);
        hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'b00);
    endfunction : hit

    // slot length minus one for source, select and multiplier
    function automatic logic [DIV_W-1:0] slot_div(input logic src,
                                                  input logic sel,
                                                  input logic mul);
        logic [2:0] key;
        key = {mul, src, sel};
        unique case (key)
            3'b000: slot_div = DIV_W'(DIV_FAST0 - 1);
            3'b001: slot_div = DIV_W'(DIV_FAST1 - 1);
            3'b010: slot_div = DIV_W'(DIV_SLOW0 - 1);
            3'b011: slot_div = DIV_W'(DIV_SLOW1 - 1);
            3'b100: slot_div = DIV_W'(DIV_FAST0_X2 - 1);
            3'b101: slot_div = DIV_W'(DIV_FAST1_X2 - 1);
            3'b110: slot_div = DIV_W'(DIV_SLOW0_X2 - 1);
            3'b111: slot_div = DIV_W'(DIV_SLOW1_X2 - 1);
        endcase
    endfunction : slot_div

    // write strobe for one register in its commit cycle
    function automatic logic wsel(input logic [ADDR_W-1:0] a,
                                  input logic c,
                                  input logic [7:0] idx);
        wsel = c && hit(a, idx);
    endfunction : wsel

    fpt_tach u_tach (
        .clk(CLK),
        .rst(RESET),
        .tif(tif.tach)
    );

    // settings and pins handed to the counter
    assign tif.preload = tif.preload_wr ? HWDATA[7:0] : preload;
    assign tif.divisor = fpt_div_t'(fan_control_setting[FCS_DIV_MSB:
                                                        FCS_DIV_LSB]);
    assign tif.ext_sel = ext_slow_clock_present;
    assign tif.slow_pin = SLOW_CLOCK_PIN;
    assign tif.pulse_in = FAN_PULSE_INPUT;
    assign tif.preload_wr = wsel(wr_addr, wr_commit, PRELOAD_IDX);

    // bus handshake: writes take one wait state so a read right behind
    // a write always sees the new value
    assign acc = HSEL && HTRANS[1] && HREADY;
    assign wr_commit = wr_ph && !wr_done;
    assign HREADYOUT = !wr_commit;
    assign HRESP = HRESP_OKAY;
    assign irq_rd_clr = acc && !HWRITE && hit(HADDR, IRQ_STS_IDX);

    // write data phase tracking
    always_ff @(posedge CLK) begin
        if (RESET) begin
            wr_ph <= 1'b0;
            wr_done <= 1'b0;
            wr_addr <= '0;
        end else if (acc) begin
            wr_ph <= HWRITE; // new address phase replaces a finished one
            wr_done <= 1'b0;
            wr_addr <= HADDR;
        end else if (wr_commit) begin
            wr_done <= 1'b1; // hold one more cycle with ready high
        end else begin
            wr_ph <= 1'b0;
        end
    end

    // read word for the address in the address phase; unmapped reads zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit(HADDR, FAN_OUTPUT_IDX)) begin
            next_rdata[7:0] = fan_output_setting;
        end else if (hit(HADDR, FAN_CONTROL_IDX)) begin
            next_rdata[7:0] = fan_control_setting;
        end else if (hit(HADDR, PRELOAD_IDX)) begin
            next_rdata[7:0] = preload;
        end else if (hit(HADDR, TACH_COUNT_IDX)) begin
            next_rdata[7:0] = tif.count;
        end else if (hit(HADDR, WAKE_STS_IDX)) begin
            next_rdata[1:0] = {WAKE_EVENT_PIN_I, wake_status};
        end else if (hit(HADDR, WAKE_EN_IDX)) begin
            next_rdata[1:0] = wake_en;
        end else if (hit(HADDR, SLOW_CFG_IDX)) begin
            next_rdata[0] = ext_slow_clock_present;
        end else if (hit(HADDR, IRQ_STS_IDX)) begin
            next_rdata[1:0] = irq_status;
        end else if (hit(HADDR, IRQ_MASK_IDX)) begin
            next_rdata[1:0] = irq_mask;
        end
    end

    // read data is registered at the address phase, zero wait states
    always_ff @(posedge CLK) begin
        if (RESET) begin
            HRDATA <= 32'h0000_0000;
        end else if (acc && !HWRITE) begin
            HRDATA <= next_rdata;
        end
    end

    // fan registers with their fixed layout
    always_ff @(posedge CLK) begin
        if (RESET) begin
            fan_output_setting <= FOS_RESET;
            fan_control_setting <= FCS_RESET; // divisor code 01
        end else begin
            if (wsel(wr_addr, wr_commit, FAN_OUTPUT_IDX)) begin
                fan_output_setting <= HWDATA[7:0];
            end
            if (wsel(wr_addr, wr_commit, FAN_CONTROL_IDX)) begin
                // unused bits are not stored and read as zero
                fan_control_setting <= HWDATA[7:0] & FCS_MASK;
            end
        end
    end

    // preload, wake enables and slow clock choice
    always_ff @(posedge CLK) begin
        if (RESET) begin
            preload <= PRELOAD_RESET;
            wake_en <= 2'b00;
            ext_slow_clock_present <= 1'b0;
        end else begin
            if (wsel(wr_addr, wr_commit, PRELOAD_IDX)) begin
                preload <= HWDATA[7:0];
            end
            if (wsel(wr_addr, wr_commit, WAKE_EN_IDX)) begin
                wake_en <= HWDATA[1:0];
            end
            if (wsel(wr_addr, wr_commit, SLOW_CFG_IDX)) begin
                ext_slow_clock_present <= HWDATA[0];
            end
        end
    end

    // wake status: set by the threshold whatever the enables, cleared by
    // writing one; a set in the clearing cycle wins
    always_ff @(posedge CLK) begin
        if (RESET) begin
            wake_status <= 1'b0;
        end else if (tif.thresh_evt) begin
            wake_status <= 1'b1;
        end else if (wsel(wr_addr, wr_commit, WAKE_STS_IDX) && HWDATA[0]) begin
            wake_status <= 1'b0;
        end
    end

    // wake pin is open drain, active low: pull low only while enabled
    assign WAKE_EVENT_PIN_O = 1'b0;
    assign WAKE_EVENT_PIN_OE = wake_status & wake_en[0];
    assign SMI_EVENT = wake_status & wake_en[1];

    // interrupt status: sticky, cleared by reading, set beats clear
    always_ff @(posedge CLK) begin
        if (RESET) begin
            irq_status <= 2'b00;
        end else begin
            irq_status <= (irq_status & {2{~irq_rd_clr}}) |
                          {tif.pulse_evt, tif.thresh_evt};
        end
    end

    // interrupt mask
    always_ff @(posedge CLK) begin
        if (RESET) begin
            irq_mask <= 2'b00;
        end else if (wsel(wr_addr, wr_commit, IRQ_MASK_IDX)) begin
            irq_mask <= HWDATA[1:0];
        end
    end

    // level interrupt while any unmasked status bit is set
    assign IRQ = |(irq_status & irq_mask);

    // slot timing: the divider length only changes at a period boundary,
    // so div_cnt can never be left above the new length
    assign slot_tick = (div_cnt == act_div);
    assign boundary = slot_tick && (slot == SLOT_LAST);

    // system clocks within a slot
    always_ff @(posedge CLK) begin
        if (RESET || slot_tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + DIV_W'(1);
        end
    end

    // 64 slots per output period
    always_ff @(posedge CLK) begin
        if (RESET) begin
            slot <= 6'h00;
        end else if (slot_tick) begin
            slot <= slot + 6'h01;
        end
    end

    // settings taken at the period boundary to avoid runt pulses
    always_ff @(posedge CLK) begin
        if (RESET) begin
            act_div <= DIV_W'(DIV_FAST0 - 1);
            act_duty <= 6'h00;
        end else if (boundary) begin
            act_div <= slot_div(fan_control_setting[FCS_SRC_BIT],
                                fan_output_setting[FOS_CLKSEL_BIT],
                                fan_control_setting[FCS_MUL_BIT]);
            act_duty <= fan_output_setting[FOS_DUTY_MSB:FOS_DUTY_LSB];
        end
    end

    // fan output: low at reset, forced high by clock control at once,
    // otherwise high while slot is below the duty code
    always_ff @(posedge CLK) begin
        if (RESET) begin
            FAN_OUT <= 1'b0;
        end else if (fan_output_setting[FOS_CLKCTL_BIT]) begin
            FAN_OUT <= 1'b1;
        end else begin
            FAN_OUT <= (slot < act_duty); // code 0 never high
        end
    end

    // the fan pin is always an output
    assign FAN_OUT_EN = 1'b1;
endmodule : fpt_top
`default_nettype wire
